// >>> logic/prb_pkg.sv
// Purpose: constants for the peripheral pin remap bank
// Assumes: 32-bit register port, byte offsets 0 and 4
// Notes: register offsets chosen locally
package prb_pkg;
   localparam logic [3:0] REG_SERIAL_OFS = 4'h0;
   localparam logic [3:0] REG_DEBUG_OFS = 4'h4;
   localparam logic [31:0] RESET_VAL = 32'h0000_0000;
   // writable masks; reserved bits read zero
   localparam logic [31:0] SERIAL_MASK = 32'hFF0F_0FFF;
   localparam logic [31:0] DEBUG_MASK = 32'h0017_033F;
   localparam int UART4_LSB = 28;
   localparam int USART3_LSB = 24;
   localparam int USART1_LSB = 16;
   localparam int SD_LSB = 8;
   localparam int CAN2_LSB = 4;
   localparam int CAN1_LSB = 0;
   localparam int XTAL_BIT = 20;
   localparam int DBG_LSB = 16;
   localparam int ADC2_REG_BIT = 9;
   localparam int ADC2_PRE_BIT = 8;
   localparam int ADC1_REG_BIT = 5;
   localparam int ADC1_PRE_BIT = 4;
   localparam int FLASH_EN_BIT = 3;
   localparam int FLASH_LSB = 0;
   localparam logic [3:0] SEL0 = 4'h0;
   localparam logic [3:0] SEL1 = 4'h1;
   localparam logic [3:0] SD_8A = 4'h0;
   localparam logic [3:0] SD_8B = 4'h4;
   localparam logic [3:0] SD_4A = 4'h5;
   localparam logic [3:0] SD_8C = 4'h6;
   localparam logic [3:0] SD_4C = 4'h7;
   localparam logic [1:0] CAN1_A = 2'h0;
   localparam logic [1:0] CAN1_B = 2'h2;
   localparam logic [2:0] DBG_FULL = 3'h0;
   localparam logic [2:0] DBG_NORST = 3'h1;
   localparam logic [2:0] DBG_SWD = 3'h2;
   localparam logic [2:0] DBG_OFF = 3'h4;
   localparam logic [2:0] FL_A = 3'h0;
   localparam logic [2:0] FL_B = 3'h1;
endpackage

// >>> logic/prb_remap_bank.sv
// Purpose: pin remap bank, routing selects and ADC trigger muxes
// Assumes: one clock, async active-low reset, plain register port
// Notes: route outputs are decoded from stored fields
// Behaviour
// - serial port4 selects PC10/11 or PF4/5
// - serial port3 moves TX/RX/CK, CTS/RTS fixed
// - serial port1 selects PA9/10 or PB6/7
// - sd codes 0,4,6 eight-bit; 5,7 four-bit
// - second can selects PB12/13 or PB5/6
// - first can code 00 or 10 only
// - crystal bit maps PD0/PD1 onto crystal pins
// - debug 000 full, 001 frees PB4
// - debug 010 swd only, 100 all free
// - adc2 regular trigger: line11 or timer8 trgo
// - adc2 preempt trigger: line15 or timer8 ch4
// - adc1 regular trigger: line11 or timer8 trgo
// - adc1 preempt trigger: line15 or timer8 ch4
// - flash enable gates quad flash pins
// - flash select moves IO0/IO1 only
`timescale 1ns/100ps
module prb_remap_bank (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic external_interrupt_line_11,
   input wire logic external_interrupt_line_15,
   input wire logic timer8_trigger_output,
   input wire logic timer8_channel4,
   output logic adc_first_regular_trigger,
   output logic adc_first_preempt_trigger,
   output logic adc_second_regular_trigger,
   output logic adc_second_preempt_trigger,
   output logic serial_port4_alt,
   output logic serial_port4_valid,
   output logic serial_port3_alt,
   output logic serial_port3_valid,
   output logic serial_port1_alt,
   output logic serial_port1_valid,
   output logic [1:0] sd_pin_set,
   output logic sd_wide_bus,
   output logic sd_valid,
   output logic can_second_alt,
   output logic can_second_valid,
   output logic can_first_alt,
   output logic can_first_valid,
   output logic crystal_pin_remap,
   output logic debug_jtag_enable,
   output logic debug_swd_enable,
   output logic debug_reset_pin_enable,
   output logic [4:0] debug_pin_gpio_free,
   output logic external_quad_flash_interface,
   output logic flash_io01_alt
);
   logic [31:0] serial_q;
   logic [31:0] debug_q;
   logic [31:0] rdata_q;
   logic [3:0] p4, p3, p1, sd, c2;
   logic [1:0] c1;
   logic [2:0] dbg, fl;
   logic [2:0] dbg_eff_q;

   // ----------------------------------------
   // register port
   // ----------------------------------------
   // reserved bits masked so software slips cannot steer anything
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         serial_q <= prb_pkg::RESET_VAL;
      end else if (reg_wr && reg_addr == prb_pkg::REG_SERIAL_OFS) begin
         serial_q <= reg_wdata & prb_pkg::SERIAL_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         debug_q <= prb_pkg::RESET_VAL;
      end else if (reg_wr && reg_addr == prb_pkg::REG_DEBUG_OFS) begin
         debug_q <= reg_wdata & prb_pkg::DEBUG_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= prb_pkg::RESET_VAL;
      end else if (reg_rd) begin
         unique case (reg_addr)
            prb_pkg::REG_SERIAL_OFS: rdata_q <= serial_q;
            prb_pkg::REG_DEBUG_OFS: rdata_q <= debug_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   assign p4 = serial_q[prb_pkg::UART4_LSB +: 4];
   assign p3 = serial_q[prb_pkg::USART3_LSB +: 4];
   assign p1 = serial_q[prb_pkg::USART1_LSB +: 4];
   assign sd = serial_q[prb_pkg::SD_LSB +: 4];
   assign c2 = serial_q[prb_pkg::CAN2_LSB +: 4];
   assign c1 = serial_q[prb_pkg::CAN1_LSB +: 2];
   assign dbg = debug_q[prb_pkg::DBG_LSB +: 3];
   assign fl = debug_q[prb_pkg::FLASH_LSB +: 3];

   assign serial_port4_alt = (p4 == prb_pkg::SEL1);
   assign serial_port4_valid = (p4 == prb_pkg::SEL0) || (p4 == prb_pkg::SEL1);
   // cts/rts never move, only tx/rx/ck follow this bit
   assign serial_port3_alt = (p3 == prb_pkg::SEL1);
   assign serial_port3_valid = (p3 == prb_pkg::SEL0) || (p3 == prb_pkg::SEL1);
   assign serial_port1_alt = (p1 == prb_pkg::SEL1);
   assign serial_port1_valid = (p1 == prb_pkg::SEL0) || (p1 == prb_pkg::SEL1);
   assign can_second_alt = (c2 == prb_pkg::SEL1);
   assign can_second_valid = (c2 == prb_pkg::SEL0) || (c2 == prb_pkg::SEL1);
   assign can_first_alt = (c1 == prb_pkg::CAN1_B);
   assign can_first_valid = (c1 == prb_pkg::CAN1_A) || (c1 == prb_pkg::CAN1_B);

   // sd pin set: 0 = PC/PB bank, 1 = PC0-3/PA4-7 ck PC4, 2 = ck PA2
   always_comb begin
      sd_pin_set = 2'h0;
      sd_wide_bus = 1'b0;
      sd_valid = 1'b1;
      case (sd)
         prb_pkg::SD_8A: begin sd_pin_set = 2'h0; sd_wide_bus = 1'b1; end
         prb_pkg::SD_8B: begin sd_pin_set = 2'h1; sd_wide_bus = 1'b1; end
         prb_pkg::SD_4A: begin sd_pin_set = 2'h1; sd_wide_bus = 1'b0; end
         prb_pkg::SD_8C: begin sd_pin_set = 2'h2; sd_wide_bus = 1'b1; end
         prb_pkg::SD_4C: begin sd_pin_set = 2'h2; sd_wide_bus = 1'b0; end
         default: sd_valid = 1'b0;
      endcase
   end

   assign crystal_pin_remap = debug_q[prb_pkg::XTAL_BIT];

   // debug: undefined codes keep the last valid mode (no effect)
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dbg_eff_q <= prb_pkg::DBG_FULL;
      end else if (reg_wr && reg_addr == prb_pkg::REG_DEBUG_OFS) begin
         if (reg_wdata[prb_pkg::DBG_LSB +: 3] == prb_pkg::DBG_FULL ||
             reg_wdata[prb_pkg::DBG_LSB +: 3] == prb_pkg::DBG_NORST ||
             reg_wdata[prb_pkg::DBG_LSB +: 3] == prb_pkg::DBG_SWD ||
             reg_wdata[prb_pkg::DBG_LSB +: 3] == prb_pkg::DBG_OFF) begin
            dbg_eff_q <= reg_wdata[prb_pkg::DBG_LSB +: 3];
         end
      end
   end

   // free bits: [0]=PA13 [1]=PA14 [2]=PA15 [3]=PB3 [4]=PB4
   always_comb begin
      debug_jtag_enable = 1'b1;
      debug_swd_enable = 1'b1;
      debug_reset_pin_enable = 1'b1;
      debug_pin_gpio_free = 5'h00;
      case (dbg_eff_q)
         prb_pkg::DBG_NORST: begin
            debug_reset_pin_enable = 1'b0;
            debug_pin_gpio_free = 5'h10;
         end
         prb_pkg::DBG_SWD: begin
            debug_jtag_enable = 1'b0;
            debug_reset_pin_enable = 1'b0;
            debug_pin_gpio_free = 5'h1C;
         end
         prb_pkg::DBG_OFF: begin
            debug_jtag_enable = 1'b0;
            debug_swd_enable = 1'b0;
            debug_reset_pin_enable = 1'b0;
            debug_pin_gpio_free = 5'h1F;
         end
         default: begin
            debug_pin_gpio_free = 5'h00;
         end
      endcase
   end

   // ----------------------------------------
   // adc trigger muxes
   // ----------------------------------------
   // combinational so triggers are not delayed a cycle
   assign adc_second_regular_trigger = debug_q[prb_pkg::ADC2_REG_BIT] ?
      timer8_trigger_output : external_interrupt_line_11;
   assign adc_second_preempt_trigger = debug_q[prb_pkg::ADC2_PRE_BIT] ?
      timer8_channel4 : external_interrupt_line_15;
   assign adc_first_regular_trigger = debug_q[prb_pkg::ADC1_REG_BIT] ?
      timer8_trigger_output : external_interrupt_line_11;
   assign adc_first_preempt_trigger = debug_q[prb_pkg::ADC1_PRE_BIT] ?
      timer8_channel4 : external_interrupt_line_15;

   // ----------------------------------------
   // quad flash
   // ----------------------------------------
   // unused select codes leave the flash off the pins
   assign external_quad_flash_interface = debug_q[prb_pkg::FLASH_EN_BIT] &&
      (fl == prb_pkg::FL_A || fl == prb_pkg::FL_B);
   assign flash_io01_alt = (fl == prb_pkg::FL_B);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_wr_serial;
      reg_wr && reg_addr == prb_pkg::REG_SERIAL_OFS;
   endsequence
   sequence s_wr_debug;
      reg_wr && reg_addr == prb_pkg::REG_DEBUG_OFS;
   endsequence

   property p_uart4;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[31:28] == 4'h1) |=> serial_port4_alt && serial_port4_valid;
   endproperty
   a_uart4: assert property (p_uart4) else $error("port4 alt not taken");

   property p_usart3;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[27:24] == 4'h2) |=> !serial_port3_valid;
   endproperty
   a_usart3: assert property (p_usart3) else $error("port3 bad code valid");

   property p_usart1;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[19:16] == 4'h0) |=> !serial_port1_alt && serial_port1_valid;
   endproperty
   a_usart1: assert property (p_usart1) else $error("port1 default lost");

   property p_sd;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[11:8] == 4'h7) |=> sd_valid && !sd_wide_bus && sd_pin_set == 2'h2;
   endproperty
   a_sd: assert property (p_sd) else $error("sd code 7 wrong");

   property p_can2;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[7:4] == 4'h1) |=> can_second_alt;
   endproperty
   a_can2: assert property (p_can2) else $error("can2 alt not taken");

   property p_can1;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[1:0] == 2'h1) |=> !can_first_valid;
   endproperty
   a_can1: assert property (p_can1) else $error("can1 code 01 valid");

   property p_xtal;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 reg_wdata[20] |=> crystal_pin_remap;
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal remap missing");

   property p_dbg_off;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 (reg_wdata[18:16] == 3'h4) |=> !debug_swd_enable && debug_pin_gpio_free == 5'h1F;
   endproperty
   a_dbg_off: assert property (p_dbg_off) else $error("debug off wrong");

   property p_dbg_noeff;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 (reg_wdata[18:16] == 3'h7) |=> $stable(debug_pin_gpio_free);
   endproperty
   a_dbg_noeff: assert property (p_dbg_noeff) else $error("debug bad code acted");

   property p_adc2r;
      @(posedge clk_sys) disable iff (!rstn)
      debug_q[9] |-> adc_second_regular_trigger == timer8_trigger_output;
   endproperty
   a_adc2r: assert property (p_adc2r) else $error("adc2 regular mux");

   property p_adc1p;
      @(posedge clk_sys) disable iff (!rstn)
      !debug_q[4] |-> adc_first_preempt_trigger == external_interrupt_line_15;
   endproperty
   a_adc1p: assert property (p_adc1p) else $error("adc1 preempt mux");

   property p_flash;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 !reg_wdata[3] |=> !external_quad_flash_interface;
   endproperty
   a_flash: assert property (p_flash) else $error("flash on while disabled");

   // one idle cycle between write and read, as the port task spaces them
   property p_rdback;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##1 !reg_wr ##1 (reg_rd && reg_addr == prb_pkg::REG_DEBUG_OFS && !reg_wr)
         |=> reg_rdata == ($past(reg_wdata, 3) & prb_pkg::DEBUG_MASK);
   endproperty
   a_rdback: assert property (p_rdback) else $error("readback mismatch");

   // no disable here: this one watches the reset itself
   property p_reset_vals;
      @(posedge clk_sys)
      !rstn |-> serial_q == prb_pkg::RESET_VAL && debug_q == prb_pkg::RESET_VAL && reg_rdata == 32'h0000_0000;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   property p_rd_idle;
      @(posedge clk_sys) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

   property p_usart3_alt;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[27:24] == 4'h1) |=> serial_port3_alt && serial_port3_valid;
   endproperty
   a_usart3_alt: assert property (p_usart3_alt) else $error("port3 alt not taken");

   property p_usart1_alt;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[19:16] == 4'h1) |=> serial_port1_alt && serial_port1_valid;
   endproperty
   a_usart1_alt: assert property (p_usart1_alt) else $error("port1 alt not taken");

   property p_sd_code5;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[11:8] == 4'h5) |=> sd_valid && !sd_wide_bus && sd_pin_set == 2'h1;
   endproperty
   a_sd_code5: assert property (p_sd_code5) else $error("sd code 5 wrong");

   property p_can1_alt;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_serial ##0 (reg_wdata[1:0] == 2'h2) |=> can_first_alt && can_first_valid;
   endproperty
   a_can1_alt: assert property (p_can1_alt) else $error("can1 alt not taken");

   property p_dbg_norst;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 (reg_wdata[18:16] == 3'h1) |=>
         debug_jtag_enable && !debug_reset_pin_enable && debug_pin_gpio_free == 5'h10;
   endproperty
   a_dbg_norst: assert property (p_dbg_norst) else $error("debug no-reset mode wrong");

   property p_dbg_swd;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 (reg_wdata[18:16] == 3'h2) |=>
         !debug_jtag_enable && debug_swd_enable && debug_pin_gpio_free == 5'h1C;
   endproperty
   a_dbg_swd: assert property (p_dbg_swd) else $error("debug swd-only mode wrong");

   property p_adc2p;
      @(posedge clk_sys) disable iff (!rstn)
      debug_q[8] |-> adc_second_preempt_trigger == timer8_channel4;
   endproperty
   a_adc2p: assert property (p_adc2p) else $error("adc2 preempt mux");

   property p_adc1r;
      @(posedge clk_sys) disable iff (!rstn)
      !debug_q[5] |-> adc_first_regular_trigger == external_interrupt_line_11;
   endproperty
   a_adc1r: assert property (p_adc1r) else $error("adc1 regular mux");

   property p_flash_sel;
      @(posedge clk_sys) disable iff (!rstn)
      s_wr_debug ##0 (reg_wdata[3:0] == 4'h9) |=> external_quad_flash_interface && flash_io01_alt;
   endproperty
   a_flash_sel: assert property (p_flash_sel) else $error("flash alt pins not taken");
endmodule // prb_remap_bank

// >>> testbench/prb_trigger_source.sv
// Purpose: trigger sources that stand beside the remap bank
// Assumes: same clock and reset as the bank
// Notes: steps through every input pattern, one per cycle
`timescale 1ns/100ps
module prb_trigger_source (
   input wire logic clk_sys,
   input wire logic rstn,
   output logic external_interrupt_line_11,
   output logic external_interrupt_line_15,
   output logic timer8_trigger_output,
   output logic timer8_channel4
);
   // ----------------------------------------
   // pattern walker
   // ----------------------------------------
   logic [3:0] phase_q;
   // all 16 patterns recur, so a wrong mux leg shows within 16 cycles
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end
   assign {external_interrupt_line_11, external_interrupt_line_15, timer8_trigger_output, timer8_channel4} = phase_q;
endmodule // prb_trigger_source

// >>> testbench/test_prb_remap_bank.sv
// Purpose: self-checking bench for the pin remap bank
// Assumes: register port with read data one cycle after the strobe
// Notes: undefined serial codes compared on their valid flags only
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_prb_remap_bank;
   logic clk_sys;
   logic rstn;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic external_interrupt_line_11, external_interrupt_line_15, timer8_trigger_output, timer8_channel4;
   logic adc_first_regular_trigger, adc_first_preempt_trigger, adc_second_regular_trigger, adc_second_preempt_trigger;
   logic serial_port4_alt, serial_port4_valid, serial_port3_alt, serial_port3_valid, serial_port1_alt;
   logic serial_port1_valid, sd_wide_bus, sd_valid, can_second_alt, can_second_valid, can_first_alt;
   logic can_first_valid, crystal_pin_remap, debug_jtag_enable, debug_swd_enable, debug_reset_pin_enable;
   logic external_quad_flash_interface, flash_io01_alt;
   logic [1:0] sd_pin_set;
   logic [4:0] debug_pin_gpio_free;
   logic [13:0] ser_v;
   logic [10:0] dbg_v;
   logic [3:0] k;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   localparam logic [31:0] ser_w [6] = '{32'h1101_0512, 32'h0000_0400, 32'h0000_0600, 32'h0000_0700,
                                         32'h2202_0321, 32'h0000_0000};
   localparam logic [13:0] ser_e [6] = '{14'h3FF5, 14'h1557, 14'h155B, 14'h1559, 14'h0000, 14'h1553};
   localparam logic [13:0] ser_m [6] = '{14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h1551, 14'h3FFF};
   localparam logic [31:0] dbg_w [6] = '{32'h0011_0009, 32'h0002_0008, 32'h0014_000A, 32'h0003_0001,
                                         32'h0007_0000, 32'h0000_0000};
   localparam logic [10:0] dbg_e [6] = '{11'h687, 11'h2E2, 11'h0FC, 11'h0F9, 11'h0F8, 11'h700};

   prb_remap_bank prb_remap_bank_i (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .external_interrupt_line_11, .external_interrupt_line_15, .timer8_trigger_output, .timer8_channel4,
      .adc_first_regular_trigger, .adc_first_preempt_trigger, .adc_second_regular_trigger,
      .adc_second_preempt_trigger, .serial_port4_alt, .serial_port4_valid, .serial_port3_alt,
      .serial_port3_valid, .serial_port1_alt, .serial_port1_valid, .sd_pin_set, .sd_wide_bus, .sd_valid,
      .can_second_alt, .can_second_valid, .can_first_alt, .can_first_valid, .crystal_pin_remap,
      .debug_jtag_enable, .debug_swd_enable, .debug_reset_pin_enable, .debug_pin_gpio_free,
      .external_quad_flash_interface, .flash_io01_alt);
   prb_trigger_source prb_trigger_source_i (.clk_sys, .rstn, .external_interrupt_line_11,
      .external_interrupt_line_15, .timer8_trigger_output, .timer8_channel4);

   assign ser_v = {serial_port4_alt, serial_port4_valid, serial_port3_alt, serial_port3_valid, serial_port1_alt,
      serial_port1_valid, can_second_alt, can_second_valid, can_first_alt, can_first_valid, sd_pin_set,
      sd_wide_bus, sd_valid};
   assign dbg_v = {debug_jtag_enable, debug_swd_enable, debug_reset_pin_enable, debug_pin_gpio_free,
      crystal_pin_remap, external_quad_flash_interface, flash_io01_alt};

   // ----------------------------------------
   // clock, timeout and closing
   // ----------------------------------------
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // whole run needs under 1000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   // ----------------------------------------
   // register port tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask

   // data only in the cycle after the strobe, zero after that
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      @(negedge clk_sys);
      `CHK(reg_rdata, e)
      @(negedge clk_sys);
      `CHK(reg_rdata, 32'h0000_0000)
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      // nonblocking so the reset flops already wait for the falling edge
      rstn <= 1'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'h1;
      @(negedge clk_sys);
      `CHK(ser_v, 14'h1553)
      `CHK(dbg_v, 11'h700)
      rd(4'h0, 32'h0000_0000);
      rd(4'h4, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wr(4'h0, ser_w[i]);
         @(negedge clk_sys);
         `CHK(ser_v & ser_m[i], ser_e[i])
         rd(4'h0, ser_w[i]);
      end
      $display("test serial remap done");
      for (int i = 0; i < 6; i++) begin
         wr(4'h4, dbg_w[i]);
         @(negedge clk_sys);
         `CHK(dbg_v, dbg_e[i])
         rd(4'h4, dbg_w[i]);
      end
      $display("test debug flash done");
      for (int i = 0; i < 16; i++) begin
         k = i[3:0];
         wr(4'h4, {22'h000000, k[3:2], 2'h0, k[1:0], 4'h0});
         repeat (16) begin
            @(negedge clk_sys);
            `CHK({adc_first_regular_trigger, adc_first_preempt_trigger, adc_second_regular_trigger, adc_second_preempt_trigger}, {k[1] ? timer8_trigger_output : external_interrupt_line_11, k[0] ? timer8_channel4 : external_interrupt_line_15, k[3] ? timer8_trigger_output : external_interrupt_line_11, k[2] ? timer8_channel4 : external_interrupt_line_15})
         end
      end
      $display("test adc triggers done");
      // every field bit set, reserved bits left at zero
      wr(4'h0, 32'hFF0F_0FFF);
      rd(4'h0, 32'hFF0F_0FFF);
      wr(4'h4, 32'h0017_033F);
      rd(4'h4, 32'h0017_033F);
      wr(4'h8, 32'h1234_5678);
      rd(4'h8, 32'h0000_0000);
      rd(4'h0, 32'hFF0F_0FFF);
      $display("test reserved unmapped done");
      @(posedge clk_sys);
      rstn <= 1'h0;
      @(negedge clk_sys);
      `CHK(ser_v, 14'h1553)
      `CHK(dbg_v, 11'h700)
      @(posedge clk_sys);
      rstn <= 1'h1;
      rd(4'h0, 32'h0000_0000);
      rd(4'h4, 32'h0000_0000);
      $display("test second reset done");
      complete_run();
   end
endmodule // test_prb_remap_bank
